// ===== hdl/excl_pkg.sv
/*
 * Shared constants and types for the exclusive access monitor.
 * Assumes nothing of its surroundings; included by compile order only.
 */
package excl_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_IDX_W = 4;

  // operation codes presented with op_valid
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LOAD = 3'b001,
    OP_STORE = 3'b010,
    OP_CLEAR = 3'b011
  } op_t;

  // access sizes, encoded as log2 of the access width in bytes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } size_t;

  // controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_STORE = 2'b10
  } state_t;

  // status values written to the status destination register
  localparam logic [DATA_W-1:0] STATUS_PASS = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STATUS_FAIL = 32'h0000_0001;

  // offset field: words of four bytes, 0..255 words = 0..1020 bytes
  localparam int OFFS_W = 8;
  localparam int OFFS_SHIFT = 2;

endpackage : excl_pkg

// ===== hdl/resv_if.sv
/*
 * Reservation carrier between the controller and the reservation tracker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps

interface resv_if;
  logic open_req;
  logic clear_req;
  logic [excl_pkg::ADDR_W-1:0] addr;
  excl_pkg::size_t size;
  logic [excl_pkg::ADDR_W-1:0] check_addr;
  excl_pkg::size_t check_size;
  logic hit;

  modport ctrl (output open_req, output clear_req, output addr, output size,
                output check_addr, output check_size, input hit);
  modport trk (input open_req, input clear_req, input addr, input size,
               input check_addr, input check_size, output hit);
endinterface : resv_if

// ===== hdl/resv_tracker.sv
/*
 * Reservation tracker: holds one open reservation (address and size).
 * Assumes snoop_valid marks a write to memory by any other agent.
 */
`timescale 1ns/10ps

module resv_tracker (
  input wire logic clk,
  input wire logic rst,
  resv_if.trk rv,
  input wire logic snoop_valid,
  input wire logic [excl_pkg::ADDR_W-1:0] snoop_addr
);

  logic open_r, open_nxt;
  logic [excl_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  excl_pkg::size_t size_r, size_nxt;

  // word-granular compare; coarser than needed, only ever fails safe
  function automatic logic same_word(input logic [excl_pkg::ADDR_W-1:0] a,
                                     input logic [excl_pkg::ADDR_W-1:0] b);
    same_word = (a[excl_pkg::ADDR_W-1:excl_pkg::OFFS_SHIFT]
                 == b[excl_pkg::ADDR_W-1:excl_pkg::OFFS_SHIFT]);
  endfunction : same_word

  // next reservation; clear and foreign access beat a fresh open
  always_comb begin
    open_nxt = open_r;
    addr_nxt = addr_r;
    size_nxt = size_r;
    if (rv.open_req) begin
      open_nxt = 1'b1;
      addr_nxt = rv.addr;
      size_nxt = rv.size;
    end
    if (rv.clear_req) begin
      open_nxt = 1'b0;
    end
    if (snoop_valid && same_word(snoop_addr, addr_nxt)) begin
      open_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      open_r <= 1'b0;
      addr_r <= '0;
      size_r <= excl_pkg::SZ_WORD;
    end else begin
      open_r <= open_nxt;
      addr_r <= addr_nxt;
      size_r <= size_nxt;
    end
  end

  // store passes only on an intact, matching reservation
  assign rv.hit = open_r && (addr_r == rv.check_addr) && (size_r == rv.check_size)
                  && !(snoop_valid && same_word(snoop_addr, addr_r));

endmodule : resv_tracker

// ===== hdl/excl_monitor.sv
/*
 * Exclusive load/store controller with one reservation.
 * Assumes a memory port with req/ack handshake and a snoop of other
 * agents' writes; flags are not touched by anything here.
 */
`timescale 1ns/10ps

// Functional notes
// - exclusive loads read and open reservation
// - performed store reports status 0
// - failed store suppressed, reports 1
// - pass guarantees no foreign access until the store is taken; snoops while its write waits are ignored
// - clear forces next store to fail
// - address is base plus optional offset
// - these operations leave flags unchanged
module excl_monitor #(
  parameter int ADDR_W = excl_pkg::ADDR_W,
  parameter int DATA_W = excl_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  // operation offered by the pipeline
  input wire logic op_valid,
  output logic op_ready,
  input wire excl_pkg::op_t op_code,
  input wire excl_pkg::size_t op_size,
  input wire logic [ADDR_W-1:0] base_reg,
  input wire logic [excl_pkg::OFFS_W-1:0] offset_words,
  input wire logic [DATA_W-1:0] store_data,
  input wire logic [excl_pkg::REG_IDX_W-1:0] dest_idx,
  // status or load data back to the register file
  output logic wb_valid,
  output logic [excl_pkg::REG_IDX_W-1:0] wb_idx,
  output logic [DATA_W-1:0] wb_data,
  // condition flags stay untouched
  output logic flags_we,
  // memory port, one access in flight
  output logic mem_req,
  output logic mem_write,
  output logic [ADDR_W-1:0] mem_addr,
  output excl_pkg::size_t mem_size,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  // accesses seen from other bus masters
  input wire logic snoop_valid,
  input wire logic [ADDR_W-1:0] snoop_addr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // operation captured when taken, held for the memory access
  excl_pkg::state_t state_r, state_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  excl_pkg::size_t size_r, size_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [excl_pkg::REG_IDX_W-1:0] idx_r, idx_nxt;
  // next values of the write-back outputs
  logic wb_valid_nxt;
  logic [excl_pkg::REG_IDX_W-1:0] wb_idx_nxt;
  logic [DATA_W-1:0] wb_data_nxt;
  logic [ADDR_W-1:0] eff_addr;

  // lane widths for the narrow loads
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;

  // ----------------------------------------------------------------
  // reservation tracker
  // ----------------------------------------------------------------
  // the tracker owns the reservation; this controller only asks for
  // open and clear and reads back whether a store may go ahead
  resv_if rv ();

  resv_tracker u_trk (
    .clk(clk),
    .rst(rst),
    .rv(rv),
    .snoop_valid(snoop_valid),
    .snoop_addr(snoop_addr)
  );

  // ----------------------------------------------------------------
  // address and data shaping
  // ----------------------------------------------------------------
  // effective address; zero offset equals the bare base register
  // narrow accesses get a zero offset from software, so one adder
  // serves every size
  assign eff_addr = base_reg + (ADDR_W'(offset_words) << excl_pkg::OFFS_SHIFT);

  // size-extend loaded data to the register width
  // zero extension only; signed narrow loads are outside this block
  function automatic logic [DATA_W-1:0] extend(input excl_pkg::size_t sz,
                                               input logic [DATA_W-1:0] d);
    case (sz)
      excl_pkg::SZ_BYTE: extend = {{(DATA_W-BYTE_W){1'b0}}, d[BYTE_W-1:0]};
      excl_pkg::SZ_HALF: extend = {{(DATA_W-HALF_W){1'b0}}, d[HALF_W-1:0]};
      default: extend = d;
    endcase
  endfunction : extend

  // ----------------------------------------------------------------
  // handshake and flags
  // ----------------------------------------------------------------
  // ready only when idle; a caller holds its request while busy
  assign op_ready = (state_r == excl_pkg::ST_IDLE);
  // flags belong to the data path; exclusive operations never touch them
  assign flags_we = 1'b0; // no operation here updates flags

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  // one access in flight; ready drops until the memory answers
  // defaults keep every register except wb_valid, which drops to 0, and leave the memory port idle,
  // so no path leaves a latch behind
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    size_nxt = size_r;
    wdata_nxt = wdata_r;
    idx_nxt = idx_r;
    wb_valid_nxt = 1'b0;
    wb_idx_nxt = wb_idx;
    wb_data_nxt = wb_data;
    rv.open_req = 1'b0;
    rv.clear_req = 1'b0;
    rv.addr = addr_r;
    rv.size = size_r;
    rv.check_addr = eff_addr;
    rv.check_size = op_size;
    mem_req = 1'b0;
    mem_write = 1'b0;
    mem_addr = addr_r;
    mem_size = size_r;
    mem_wdata = wdata_r;
    case (state_r)
      // take one operation; a store is judged in the cycle it is taken
      excl_pkg::ST_IDLE: begin
        if (op_valid) begin
          addr_nxt = eff_addr;
          size_nxt = op_size;
          wdata_nxt = store_data;
          idx_nxt = dest_idx;
          case (op_code)
            excl_pkg::OP_LOAD: begin
              state_nxt = excl_pkg::ST_LOAD;
            end
            excl_pkg::OP_STORE: begin
              if (rv.hit) begin
                state_nxt = excl_pkg::ST_STORE;
              end else begin
                wb_valid_nxt = 1'b1; // no memory write
                wb_idx_nxt = dest_idx;
                wb_data_nxt = excl_pkg::STATUS_FAIL;
              end
              // any store ends the reservation, pass or fail, so a second
              // store without a fresh load always fails
              rv.clear_req = 1'b1; // reservation is spent either way
            end
            excl_pkg::OP_CLEAR: begin
              rv.clear_req = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      // read stands until the memory answers; reservation opens then
      excl_pkg::ST_LOAD: begin
        mem_req = 1'b1;
        if (mem_ack) begin
          rv.open_req = 1'b1;
          wb_valid_nxt = 1'b1;
          wb_idx_nxt = idx_r;
          wb_data_nxt = extend(size_r, mem_rdata);
          state_nxt = excl_pkg::ST_IDLE;
        end
      end
      // write granted on a live reservation; status 0 once it lands
      excl_pkg::ST_STORE: begin
        mem_req = 1'b1;
        mem_write = 1'b1;
        if (mem_ack) begin
          wb_valid_nxt = 1'b1;
          wb_idx_nxt = idx_r;
          wb_data_nxt = excl_pkg::STATUS_PASS;
          state_nxt = excl_pkg::ST_IDLE;
        end
      end
      // unused code: recover to idle
      default: begin
        state_nxt = excl_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // write-back outputs come straight from flops, a one-cycle pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= excl_pkg::ST_IDLE;
      addr_r <= '0;
      size_r <= excl_pkg::SZ_WORD;
      wdata_r <= '0;
      idx_r <= '0;
      wb_valid <= 1'b0;
      wb_idx <= '0;
      wb_data <= '0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      size_r <= size_nxt;
      wdata_r <= wdata_nxt;
      idx_r <= idx_nxt;
      wb_valid <= wb_valid_nxt;
      wb_idx <= wb_idx_nxt;
      wb_data <= wb_data_nxt;
    end
  end

endmodule : excl_monitor

// ===== testbench/mem_model.sv
/* memory partner: word array answering req with ack after lat+1 cycles.
   assumes req and its qualifiers hold until ack. */
`timescale 1ns/10ps
module mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [1:0] lat,
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem_r [16];
  logic [1:0] cnt_r;
  // each word holds its index in every byte, so words are easy to tell apart
  initial for (int i = 0; i < 16; i++) mem_r[i] = 32'(i) * 32'h0101_0101;
  // rdata flips when not answering, so stale data never looks valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'h0;
      ack <= 1'b0;
      rdata <= 32'h0;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == lat) begin
          ack <= 1'b1;
          cnt_r <= 2'h0;
          if (wr) mem_r[addr[5:2]] <= wdata;
          else rdata <= mem_r[addr[5:2]];
        end
      end
    end
  end
endmodule : mem_model

// ===== testbench/excl_monitor_checker.sv
/* port assertions and covers for excl_monitor.
   assumes one clock domain, reset async active high. */
`timescale 1ns/10ps
module excl_monitor_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire excl_pkg::op_t op_code,
  input wire excl_pkg::size_t op_size,
  input wire logic wb_valid,
  input wire logic [31:0] wb_data,
  input wire logic flags_we,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire excl_pkg::size_t mem_size,
  input wire logic mem_ack,
  input wire logic snoop_valid,
  input wire logic [31:0] snoop_addr
);
  logic st, clr_r, none_r, snp_r;
  logic [31:0] res_r;
  assign st = op_valid && op_ready && op_code == excl_pkg::OP_STORE;
  // why the next store must fail; wb-cycle snoops skipped, their order is open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {clr_r, none_r, snp_r} <= 3'h2;
      res_r <= 32'h0;
    end else if (mem_ack && !mem_write) begin
      {clr_r, none_r, snp_r} <= 3'h0;
      res_r <= mem_addr;
    end else begin
      clr_r <= clr_r | (op_valid && op_ready && op_code == excl_pkg::OP_CLEAR);
      none_r <= none_r | st;
      snp_r <= snp_r | (snoop_valid && !wb_valid && snoop_addr[31:2] == res_r[31:2]);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_flags; !flags_we; endproperty
  a_flags: assert property (p_flags) else $error("flags written");
  property p_load;
    op_valid && op_ready && op_code == excl_pkg::OP_LOAD |=> mem_req && !mem_write;
  endproperty
  a_load: assert property (p_load) else $error("load not issued");
  property p_wb; mem_ack && !mem_write |=> wb_valid; endproperty
  a_wb: assert property (p_wb) else $error("load not returned");
  property p_pass; mem_ack && mem_write |=> wb_valid && wb_data == excl_pkg::STATUS_PASS;
  endproperty
  a_pass: assert property (p_pass) else $error("pass status");
  property p_fail; st ##1 !mem_req |-> wb_valid && wb_data == excl_pkg::STATUS_FAIL;
  endproperty
  a_fail: assert property (p_fail) else $error("fail status");
  property p_clear; st && clr_r |=> !mem_req && wb_valid; endproperty
  a_clear: assert property (p_clear) else $error("store after clear");
  property p_nores; st && none_r |=> !mem_req && wb_data == excl_pkg::STATUS_FAIL;
  endproperty
  a_nores: assert property (p_nores) else $error("store unreserved");
  property p_snoop; st && snp_r |=> !mem_req && wb_valid; endproperty
  a_snoop: assert property (p_snoop) else $error("store after snoop");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_size;
    op_valid && op_ready && op_code == excl_pkg::OP_LOAD |=> mem_size == $past(op_size);
  endproperty
  a_size: assert property (p_size) else $error("load size");
  c_pass: cover property (mem_ack && mem_write);
  c_clear: cover property (st && clr_r);
  c_snoop: cover property (st && snp_r);
endmodule : excl_monitor_checker
bind excl_monitor excl_monitor_checker i_chk (.clk(clk), .rst(rst), .op_valid(op_valid),
  .op_ready(op_ready), .op_code(op_code), .op_size(op_size), .wb_valid(wb_valid),
  .wb_data(wb_data), .flags_we(flags_we), .mem_req(mem_req), .mem_write(mem_write),
  .mem_addr(mem_addr), .mem_size(mem_size), .mem_ack(mem_ack),
  .snoop_valid(snoop_valid), .snoop_addr(snoop_addr));

// ===== testbench/tb_top.sv
/* self-checking bench: excl_monitor against mem_model.
   assumes package, model and checker compiled first. */
`timescale 1ns/10ps
module tb_top;
  logic clk, rst, op_valid, op_ready, wb_valid, flags_we, mem_req, mem_write, mem_ack;
  logic snoop_valid;
  excl_pkg::op_t op_code;
  excl_pkg::size_t op_size, mem_size;
  logic [31:0] base_reg, store_data, wb_data, mem_addr, mem_wdata, mem_rdata, snoop_addr;
  logic [7:0] offset_words;
  logic [3:0] dest_idx, wb_idx;
  logic [1:0] lat;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  excl_monitor i_excl_monitor (.clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_size(op_size), .base_reg(base_reg), .offset_words(offset_words),
    .store_data(store_data), .dest_idx(dest_idx), .wb_valid(wb_valid), .wb_idx(wb_idx),
    .wb_data(wb_data), .flags_we(flags_we), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .snoop_valid(snoop_valid), .snoop_addr(snoop_addr));
  mem_model i_mem (.clk(clk), .rst(rst), .req(mem_req), .wr(mem_write), .addr(mem_addr),
    .wdata(mem_wdata), .lat(lat), .ack(mem_ack), .rdata(mem_rdata));
  // ----------------------------------------
  // drivers and judges
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // issued only when idle, so the edge after raising op_valid takes it
  task automatic op(input excl_pkg::op_t c, input excl_pkg::size_t s, input logic [31:0] b,
                    input logic [7:0] o, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    op_code <= c;
    op_size <= s;
    {base_reg, offset_words, store_data} <= {b, o, d};
    dest_idx <= {1'b0, dest_idx[2:0] + 3'h1};
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    r = 'x;
    #1;
    for (int n = 0; n < 20 && c != excl_pkg::OP_CLEAR && wb_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (wb_valid === 1'b1) begin
      r = wb_data;
      chk(32'(wb_idx), 32'(dest_idx));
    end
  endtask : op
  task automatic t_pairs;
    logic [31:0] r, v, a;
    for (int k = 0; k < 3; k++) begin
      lat <= 2'(k);
      v = (k + 2) * 32'h0101_0101;
      a = 32'(4 * k + 8);
      op(excl_pkg::OP_LOAD, excl_pkg::size_t'(k), a, 8'h00, 32'h0, r);
      chk(r, k == 0 ? v & 32'hFF : k == 1 ? v & 32'hFFFF : v);
      op(excl_pkg::OP_STORE, excl_pkg::size_t'(k), a, 8'h00, 32'hAB, r);
      chk(r, excl_pkg::STATUS_PASS);
    end
    chk(i_mem.mem_r[4], 32'hAB);
    op(excl_pkg::OP_STORE, excl_pkg::SZ_WORD, 32'h10, 8'h00, 32'hCD, r);
    chk(r, excl_pkg::STATUS_FAIL);
    chk(i_mem.mem_r[4], 32'hAB);
  endtask : t_pairs
  task automatic t_clear;
    logic [31:0] r;
    op(excl_pkg::OP_LOAD, excl_pkg::SZ_WORD, 32'h14, 8'h00, 32'h0, r);
    op(excl_pkg::OP_CLEAR, excl_pkg::SZ_WORD, 32'h0, 8'h00, 32'h0, r);
    op(excl_pkg::OP_STORE, excl_pkg::SZ_WORD, 32'h14, 8'h00, 32'hEE, r);
    chk(r, excl_pkg::STATUS_FAIL);
    chk(i_mem.mem_r[5], 32'h0505_0505);
  endtask : t_clear
  // largest offset, then a foreign write to the reserved word
  task automatic t_snoop;
    logic [31:0] r;
    lat <= 2'h3;
    op(excl_pkg::OP_LOAD, excl_pkg::SZ_WORD, 32'h40, 8'hFF, 32'h0, r);
    chk(r, 32'h0F0F_0F0F);
    @(posedge clk);
    snoop_addr <= 32'h43C;
    snoop_valid <= 1'b1;
    @(posedge clk);
    snoop_valid <= 1'b0;
    op(excl_pkg::OP_STORE, excl_pkg::SZ_WORD, 32'h40, 8'hFF, 32'h77, r);
    chk(r, excl_pkg::STATUS_FAIL);
    chk(i_mem.mem_r[15], 32'h0F0F_0F0F);
  endtask : t_snoop
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard: the whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    {rst, op_valid, snoop_valid, lat, dest_idx} = {3'b100, 2'h0, 4'h3};
    op_code = excl_pkg::OP_NONE;
    op_size = excl_pkg::SZ_WORD;
    {base_reg, offset_words} = 40'h0;
    {store_data, snoop_addr} = 64'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_pairs();
    t_clear();
    t_snoop();
    give_verdict();
  end
endmodule : tb_top
